// file: rtl/hst_pkg.sv
// Package of constants for the high speed 10-bit timer core
package hst_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          CNT_W         = 10;
  localparam int          FINE_W        = 11;
  localparam int          DIV_W         = 15;
  localparam logic [7:0]  OFS_COUNT     = 8'h00;
  localparam logic [7:0]  OFS_UBUF      = 8'h04;
  localparam logic [7:0]  OFS_CMP_A     = 8'h08;
  localparam logic [7:0]  OFS_CMP_B     = 8'h0c;
  localparam logic [7:0]  OFS_TOP       = 8'h10;
  localparam logic [7:0]  OFS_CMP_D     = 8'h14;
  localparam logic [7:0]  OFS_CTRL_D    = 8'h18;
  localparam logic [7:0]  OFS_MASK      = 8'h1c;
  localparam logic [7:0]  OFS_FLAGS     = 8'h20;
  localparam logic [7:0]  OFS_CLKSEL    = 8'h24;
  // Flag and mask bit positions
  localparam int          BIT_OVF       = 0;
  localparam int          BIT_A         = 1;
  localparam int          BIT_B         = 2;
  localparam int          BIT_D         = 3;
  // Control register D bit positions
  localparam int          BIT_FIE       = 0;
  localparam int          BIT_FF        = 1;
  localparam int          BIT_ENH       = 2;
  // Clock select register fields
  localparam int          CSEL_LSB      = 0;
  localparam int          PLLSEL_LSB    = 4;
  localparam logic [9:0]  TOP_RST       = 10'h0ff;
  localparam logic [3:0]  CSEL_STOP     = 4'h0;
  localparam logic [1:0]  PLLSEL_SYNC   = 2'h0;
endpackage

// file: rtl/hst_tick_if.sv
// Interface between the timer core and its prescaler
`timescale 1ns/10ps
`default_nettype none
interface hst_tick_if;
  logic [3:0] clock_source_sel;
  logic [1:0] pll_postscaler_sel;
  logic       enhanced;
  logic       tick;
  modport core (output clock_source_sel, output pll_postscaler_sel, output enhanced, input tick);
  modport presc (input clock_source_sel, input pll_postscaler_sel, input enhanced, output tick);
endinterface
`default_nettype wire

// file: rtl/hst_sync_stage.sv
// One register stage used as input or output synchroniser
`timescale 1ns/10ps
`default_nettype none
module hst_sync_stage #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dout <= '0;
    end else if (load) begin
      dout <= din;
    end
  end
endmodule
`default_nettype wire

// file: rtl/hst_prescaler.sv
// Timer clock prescaler with synchronous and fast clock sources
`timescale 1ns/10ps
`default_nettype none
module hst_prescaler
  import hst_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic fast_peripheral_clock,
  hst_tick_if.presc tif
);
  typedef struct packed {
    logic             pck_s1;
    logic             pck_s2;
    logic             pck_s3;
    logic [DIV_W-1:0] div;
    logic             tick;
  } hst_presc_s;

  hst_presc_s st_r;
  hst_presc_s st_nxt;

  always_comb begin
    logic             base;
    logic [DIV_W-1:0] lim;
    logic [3:0]       shift;
    base   = 1'b0;
    lim    = '0;
    shift  = 4'h0;
    st_nxt = st_r;
    st_nxt.pck_s1 = fast_peripheral_clock;
    st_nxt.pck_s2 = st_r.pck_s1;
    st_nxt.pck_s3 = st_r.pck_s2;
    // Fast clock edges counted, not used as a clock: single domain
    if (tif.pll_postscaler_sel != PLLSEL_SYNC) begin
      base = st_r.pck_s2 & ~st_r.pck_s3;
    end else begin
      base = 1'b1;
    end
    if (tif.clock_source_sel != CSEL_STOP) begin
      shift = tif.clock_source_sel - 4'h1;
    end
    // Enhanced mode halves any divider above 1 so PWM frequency is unchanged
    if (tif.enhanced && shift != 4'h0) begin
      shift = shift - 4'h1;
    end
    lim = DIV_W'((1 << shift) - 1);
    st_nxt.tick = 1'b0;
    if (tif.clock_source_sel == CSEL_STOP) begin
      st_nxt.div = '0;
    end else if (base) begin
      if (st_r.div >= lim) begin
        st_nxt.div  = '0;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.div = st_r.div + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tif.tick = st_r.tick;
endmodule
`default_nettype wire

// file: rtl/hst_timer.sv
// Top of the high speed 10-bit timer core with APB register access
//
// Overview of operation
// - Counter is 10 bits wide, compares 11 bits in enhanced mode
// - Zero upper bits give plain 8-bit timer
// - One shared upper bits buffer register
// - Low byte read loads upper bits buffer
// - Low byte write takes upper bits from buffer
// - Enhanced mode adds resolution, same frequency above divide by 1
// - Buffer gains third bit in enhanced mode
// - Compares A, B, D drive pins, flags
// - Top register clears counter on match
// - Flags register plus fault flag in control D
// - Each source masked individually
// - Async mode counts fast peripheral clock
// - Compare, top and enhanced bit writes pass input synchronisers first
// - Control and compare read back immediately
// - Count, buffer, flags read back delayed
// - Nonzero postscaler select means async mode
// - Zero clock select stops the counter
// - Compare flag set next timer tick
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module hst_timer
  import hst_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [hst_pkg::ADDR_W-1:0] paddr,
  input  wire logic [hst_pkg::DATA_W-1:0] pwdata,
  output var  logic [hst_pkg::DATA_W-1:0] prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  input  wire logic                      fast_peripheral_clock,
  input  wire logic                      fault_in,
  output var  logic                      wave_out_a,
  output var  logic                      wave_out_b,
  output var  logic                      wave_out_d,
  output var  logic                      irq_req
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0]        ubuf;
    logic [FINE_W-1:0] cmp_a;
    logic [FINE_W-1:0] cmp_b;
    logic [FINE_W-1:0] cmp_d;
    logic [CNT_W-1:0]  top;
    logic [2:0]        ctl_d;
    logic [3:0]        mask;
    logic [3:0]        clksel;
    logic [1:0]        pllsel;
    logic [CNT_W-1:0]  cnt_wr;
    logic              cnt_wr_req;
    logic [FINE_W-1:0] fine;
    logic [3:0]        flags;
    logic [2:0]        pend;
    logic              block;
    logic [DATA_W-1:0] rdata;
    logic              ready;
    logic              err;
    logic              wa;
    logic              wb;
    logic              wd;
    logic              irq;
  } hst_state_s;

  hst_state_s st_r;
  hst_state_s st_nxt;

  hst_tick_if tif ();

  localparam int SI_W = 3 * FINE_W + CNT_W + 2;
  localparam int SO_W = CNT_W + 4 + 3;

  logic [SI_W-1:0] si_q;
  logic [SO_W-1:0] so_q;
  logic            async_mode;
  logic            si_load;

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  // Async mode reloads only on timer ticks; sync mode every cycle
  assign async_mode = (st_r.pllsel != PLLSEL_SYNC);
  assign si_load    = ~async_mode | tif.tick;

  hst_sync_stage #(.WIDTH(SI_W)) u_in_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (si_load),
    .din     ({st_r.cmp_a, st_r.cmp_b, st_r.cmp_d, st_r.top, st_r.ctl_d[BIT_ENH],
               st_r.ctl_d[BIT_ENH]}),
    .dout    (si_q)
  );

  hst_sync_stage #(.WIDTH(SO_W)) u_out_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (1'b1),
    .din     ({st_r.fine[FINE_W-1:1], st_r.flags, st_r.ubuf}),
    .dout    (so_q)
  );

  hst_prescaler u_presc (
    .ref_clk               (ref_clk),
    .reset                 (reset),
    .fast_peripheral_clock (fast_peripheral_clock),
    .tif                   (tif.presc)
  );

  assign tif.clock_source_sel   = st_r.clksel;
  assign tif.pll_postscaler_sel = st_r.pllsel;
  assign tif.enhanced           = st_r.ctl_d[BIT_ENH];

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [FINE_W-1:0] si_a;
    logic [FINE_W-1:0] si_b;
    logic [FINE_W-1:0] si_d;
    logic [CNT_W-1:0]  si_top;
    logic              si_enh;
    logic [CNT_W-1:0]  so_cnt;
    logic [3:0]        so_flags;
    logic [2:0]        so_ubuf;
    logic              setup;
    logic              wr;
    logic              rd;
    logic [7:0]        wb8;
    logic [3:0]        set_f;
    logic [3:0]        clr_f;
    logic              at_top;
    logic [2:0]        hit;
    logic [FINE_W-1:0] step;
    logic [2:0]        ub_mask;
    si_a     = si_q[SI_W-1 -: FINE_W];
    si_b     = si_q[SI_W-1-FINE_W -: FINE_W];
    si_d     = si_q[SI_W-1-2*FINE_W -: FINE_W];
    si_top   = si_q[CNT_W+1:2];
    si_enh   = si_q[1];
    so_cnt   = so_q[SO_W-1 -: CNT_W];
    so_flags = so_q[6:3];
    so_ubuf  = so_q[2:0];
    st_nxt   = st_r;
    setup    = psel & ~penable & ~st_r.ready;
    wr       = psel & penable & st_r.ready & pwrite;
    rd       = psel & penable & st_r.ready & ~pwrite;
    wb8      = pwdata[7:0];
    set_f    = 4'h0;
    clr_f    = 4'h0;
    at_top   = 1'b0;
    hit      = 3'h0;
    step     = '0;
    // Third buffer bit only exists in enhanced mode
    ub_mask  = st_r.ctl_d[BIT_ENH] ? 3'h7 : 3'h3;

    // --------------------------------------------------------
    // APB slave: zero wait, answer registered in setup cycle
    // --------------------------------------------------------
    st_nxt.ready = setup;
    st_nxt.err   = 1'b0;
    if (setup) begin
      st_nxt.rdata = '0;
      unique case (paddr)
        OFS_COUNT:  st_nxt.rdata[7:0] = so_cnt[7:0];
        OFS_UBUF:   st_nxt.rdata[2:0] = so_ubuf;
        OFS_CMP_A:  st_nxt.rdata[7:0] = st_r.cmp_a[7:0];
        OFS_CMP_B:  st_nxt.rdata[7:0] = st_r.cmp_b[7:0];
        OFS_TOP:    st_nxt.rdata[7:0] = st_r.top[7:0];
        OFS_CMP_D:  st_nxt.rdata[7:0] = st_r.cmp_d[7:0];
        OFS_CTRL_D: st_nxt.rdata[2:0] = st_r.ctl_d;
        OFS_MASK:   st_nxt.rdata[3:0] = st_r.mask;
        OFS_FLAGS:  st_nxt.rdata[3:0] = so_flags;
        OFS_CLKSEL: st_nxt.rdata[5:0] = {st_r.pllsel, st_r.clksel};
        default:    st_nxt.err = 1'b1;
      endcase
    end else begin
      // Read data stands only in the access cycle
      st_nxt.rdata = '0;
    end

    // Reading a low byte parks its upper bits in the buffer
    if (rd) begin
      case (paddr)
        OFS_COUNT: st_nxt.ubuf = {1'b0, so_cnt[9:8]};
        OFS_CMP_A: st_nxt.ubuf = st_r.cmp_a[10:8] & ub_mask;
        OFS_CMP_B: st_nxt.ubuf = st_r.cmp_b[10:8] & ub_mask;
        OFS_TOP:   st_nxt.ubuf = {1'b0, st_r.top[9:8]};
        OFS_CMP_D: st_nxt.ubuf = st_r.cmp_d[10:8] & ub_mask;
        default:   st_nxt.ubuf = st_r.ubuf;
      endcase
    end

    // Writing a low byte merges the buffered upper bits
    if (wr) begin
      case (paddr)
        OFS_COUNT: begin
          st_nxt.cnt_wr     = {st_r.ubuf[1:0], wb8};
          st_nxt.cnt_wr_req = 1'b1;
        end
        OFS_UBUF:   st_nxt.ubuf  = wb8[2:0] & ub_mask;
        OFS_CMP_A:  st_nxt.cmp_a = {st_r.ubuf & ub_mask, wb8};
        OFS_CMP_B:  st_nxt.cmp_b = {st_r.ubuf & ub_mask, wb8};
        OFS_TOP:    st_nxt.top   = {st_r.ubuf[1:0], wb8};
        OFS_CMP_D:  st_nxt.cmp_d = {st_r.ubuf & ub_mask, wb8};
        OFS_CTRL_D: begin
          st_nxt.ctl_d[BIT_FIE] = wb8[BIT_FIE];
          st_nxt.ctl_d[BIT_ENH] = wb8[BIT_ENH];
        end
        OFS_MASK:   st_nxt.mask = wb8[3:0];
        OFS_FLAGS:  clr_f = wb8[3:0];
        OFS_CLKSEL: begin
          st_nxt.clksel = wb8[CSEL_LSB +: 4];
          st_nxt.pllsel = wb8[PLLSEL_LSB +: 2];
        end
        default: ;
      endcase
    end

    // --------------------------------------------------------
    // Counter and compare on each timer tick
    // --------------------------------------------------------
    // Normal mode steps two half-counts so the fine bit stays zero
    step   = si_enh ? FINE_W'(1) : FINE_W'(2);
    at_top = (st_r.fine[FINE_W-1:1] == si_top) && (!si_enh || st_r.fine[0]);
    if (si_enh) begin
      hit = {st_r.fine == si_a, st_r.fine == si_b, st_r.fine == si_d};
    end else begin
      hit = {st_r.fine[FINE_W-1:1] == si_a[CNT_W-1:0],
             st_r.fine[FINE_W-1:1] == si_b[CNT_W-1:0],
             st_r.fine[FINE_W-1:1] == si_d[CNT_W-1:0]};
    end
    if (tif.tick) begin
      // Matches found now become flags one tick later
      if (!st_r.block) begin
        set_f[BIT_A] = st_r.pend[2];
        set_f[BIT_B] = st_r.pend[1];
        set_f[BIT_D] = st_r.pend[0];
      end
      st_nxt.pend  = hit;
      st_nxt.block = 1'b0;
      if (st_r.cnt_wr_req) begin
        // CPU write beats count and clear, and masks the next match
        st_nxt.fine       = {st_r.cnt_wr, 1'b0};
        st_nxt.cnt_wr_req = 1'b0;
        st_nxt.block      = 1'b1;
        st_nxt.pend       = 3'h0;
      end else if (at_top) begin
        st_nxt.fine    = '0;
        set_f[BIT_OVF] = 1'b1;
        st_nxt.wa      = 1'b1;
        st_nxt.wb      = 1'b1;
        st_nxt.wd      = 1'b1;
      end else begin
        st_nxt.fine = st_r.fine + step;
      end
      if (!st_r.cnt_wr_req && !at_top) begin
        if (hit[2]) st_nxt.wa = 1'b0;
        if (hit[1]) st_nxt.wb = 1'b0;
        if (hit[0]) st_nxt.wd = 1'b0;
      end
    end else if (st_r.clksel == CSEL_STOP && st_r.cnt_wr_req) begin
      // Stopped timer still takes a count write
      st_nxt.fine       = {st_r.cnt_wr, 1'b0};
      st_nxt.cnt_wr_req = 1'b0;
      st_nxt.block      = 1'b1;
    end

    // Set wins over a clear arriving in the same cycle
    st_nxt.flags = (st_r.flags & ~clr_f) | set_f;
    if (fault_in) begin
      st_nxt.ctl_d[BIT_FF] = 1'b1;
    end else if (wr && paddr == OFS_CTRL_D && wb8[BIT_FF]) begin
      st_nxt.ctl_d[BIT_FF] = 1'b0;
    end

    st_nxt.irq = |(st_r.flags & st_r.mask)
               | (st_r.ctl_d[BIT_FF] & st_r.ctl_d[BIT_FIE]);
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r     <= '0;
      st_r.top <= TOP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata     = st_r.rdata;
  assign pready     = st_r.ready;
  assign pslverr    = st_r.err;
  assign wave_out_a = st_r.wa;
  assign wave_out_b = st_r.wb;
  assign wave_out_d = st_r.wd;
  assign irq_req    = st_r.irq;
endmodule
`default_nettype wire

// file: test/hst_timer_assertions.sv
// Assertions on the timer core ports
`timescale 1ns/10ps
`default_nettype none
module hst_timer_chk
  import hst_pkg::*;
(
  input wire logic                       ref_clk,
  input wire logic                       reset,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [hst_pkg::ADDR_W-1:0] paddr,
  input wire logic [hst_pkg::DATA_W-1:0] pwdata,
  input wire logic [hst_pkg::DATA_W-1:0] prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       fast_peripheral_clock,
  input wire logic                       fault_in,
  input wire logic                       wave_out_a,
  input wire logic                       wave_out_b,
  input wire logic                       wave_out_d,
  input wire logic                       irq_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic bad;
  assign bad = (paddr > OFS_CLKSEL) || (paddr[1:0] != 2'h0);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  chk_byte_wide_data: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data above low byte");
  chk_buffer_width: assert property (pready && paddr == OFS_UBUF |-> prdata[7:3] == 5'h0)
    else $error("upper bits buffer too wide");
  chk_unmapped_error: assert property (pready && bad |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_okay: assert property (pready && !bad |-> !pslverr)
    else $error("mapped access refused");
  chk_reset_quiet: assert property ($fell(reset) |-> !irq_req && !wave_out_a && !wave_out_b && !wave_out_d)
    else $error("outputs active after reset");
  cover property (pready && pwrite);
  cover property (pslverr);
  cover property ($rose(irq_req));
  cover property ($rose(wave_out_a));
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking testbench for the timer core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import hst_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fast_peripheral_clock = 1'b0;
  logic        fault_in = 1'b0;
  logic        wave_out_a;
  logic        wave_out_b;
  logic        wave_out_d;
  logic        irq_req;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic        err;
  logic [7:0]  dif;
  logic [1:0]  fdiv = 2'h0;
  int          n_errors = 0;
  int          cmp_count = 0;

  always #5 ref_clk = ~ref_clk;
  // Fast clock toggles every 3 cycles, below half the system rate
  always @(posedge ref_clk) begin
    fdiv <= (fdiv == 2'h2) ? 2'h0 : fdiv + 2'h1;
    if (fdiv == 2'h2) fast_peripheral_clock <= ~fast_peripheral_clock;
  end

  hst_timer i_dut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_in(fault_in),
    .fast_peripheral_clock(fast_peripheral_clock), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .wave_out_d(wave_out_d), .irq_req(irq_req)
  );

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // Waits for pready; only the watchdog ends a hung wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic r(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  task automatic irq_is(input logic exp);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq_req}, {31'h0, exp});
  endtask

  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    r(OFS_TOP, 32'hff);
    r(OFS_CMP_A, 32'h0);
    r(OFS_CLKSEL, 32'h0);
    apb(1'b0, 8'h40, 8'h00);
    chk({31'h0, err}, 32'h1);
  endtask

  task automatic t_wide();
    w(OFS_UBUF, 8'h03);
    w(OFS_CMP_B, 8'h5a);
    w(OFS_UBUF, 8'h00);
    r(OFS_CMP_B, 32'h5a);
    r(OFS_UBUF, 32'h3);
    w(OFS_UBUF, 8'h00);
    w(OFS_CMP_D, 8'h11);
    r(OFS_CMP_D, 32'h11);
    r(OFS_UBUF, 32'h0);
    // Count write on a stopped timer; readback lags by the sync stages
    w(OFS_UBUF, 8'h02);
    w(OFS_COUNT, 8'h34);
    repeat (2) @(posedge ref_clk);
    r(OFS_COUNT, 32'h34);
    r(OFS_UBUF, 32'h2);
    w(OFS_UBUF, 8'h00);
    w(OFS_COUNT, 8'h00);
    repeat (2) @(posedge ref_clk);
    r(OFS_COUNT, 32'h0);
    r(OFS_UBUF, 32'h0);
  endtask

  task automatic t_run();
    w(OFS_TOP, 8'h05);
    w(OFS_CMP_A, 8'h02);
    w(OFS_MASK, 8'h03);
    w(OFS_CLKSEL, 8'h01);
    repeat (20) @(posedge ref_clk);
    w(OFS_CLKSEL, 8'h00);
    r(OFS_FLAGS, 32'h3);
    irq_is(1'b1);
    apb(1'b0, OFS_COUNT, 8'h00);
    rd2 = rd;
    // Pin A set at wrap, cleared after count 2; B and D never hit
    chk({31'h0, wave_out_a}, {31'h0, rd2 < 32'h3});
    chk({31'h0, wave_out_b}, 32'h1);
    chk({31'h0, wave_out_d}, 32'h1);
    repeat (5) @(posedge ref_clk);
    r(OFS_COUNT, rd2);
    chk({31'h0, rd <= 32'h5}, 32'h1);
    w(OFS_MASK, 8'h04);
    irq_is(1'b0);
    w(OFS_MASK, 8'h03);
    irq_is(1'b1);
    w(OFS_FLAGS, 8'h0f);
    r(OFS_FLAGS, 32'h0);
    irq_is(1'b0);
  endtask

  task automatic t_fault();
    @(posedge ref_clk);
    fault_in <= 1'b1;
    repeat (3) @(posedge ref_clk);
    fault_in <= 1'b0;
    r(OFS_CTRL_D, 32'h2);
    irq_is(1'b0);
    w(OFS_CTRL_D, 8'h01);
    irq_is(1'b1);
    w(OFS_CTRL_D, 8'h03);
    r(OFS_CTRL_D, 32'h1);
    irq_is(1'b0);
  endtask

  task automatic t_enh();
    w(OFS_CTRL_D, 8'h04);
    w(OFS_UBUF, 8'h07);
    r(OFS_UBUF, 32'h7);
    w(OFS_CTRL_D, 8'h00);
    w(OFS_UBUF, 8'h07);
    r(OFS_UBUF, 32'h3);
  endtask

  task automatic t_async();
    w(OFS_UBUF, 8'h00);
    w(OFS_TOP, 8'hff);
    w(OFS_CLKSEL, 8'h11);
    apb(1'b0, OFS_COUNT, 8'h00);
    rd2 = rd;
    repeat (36) @(posedge ref_clk);
    apb(1'b0, OFS_COUNT, 8'h00);
    dif = rd[7:0] - rd2[7:0];
    // One tick per rising fast edge, not per system cycle
    chk({31'h0, dif >= 8'h3 && dif <= 8'ha}, 32'h1);
    w(OFS_CLKSEL, 8'h00);
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_wide();
    t_run();
    t_fault();
    t_enh();
    t_async();
    test_done();
  end

  initial begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule

bind hst_timer hst_timer_chk u_chk (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fault_in(fault_in),
  .fast_peripheral_clock(fast_peripheral_clock), .wave_out_a(wave_out_a),
  .wave_out_b(wave_out_b), .wave_out_d(wave_out_d), .irq_req(irq_req)
);
`default_nettype wire
